//--- logic/cbb_bridge.sv
// Processor-bus slave bridging to DRAM and to the VL-bus.
// How it works
// - Transceiver emulation strap high; address and data latched inside.
// - A newer latched address replaces an older one before cycle start.
// - Writes enter an eight-qword queue; empty queue holds two bursts.
// - Memory write ends three clocks after address latch; drained later.
// - Wait states on writes only when the queue is full.
// - Latch enable one clock, strobe next clock, decode the clock after.
// - Write data latched with latch enable; ack given, hold negated.
// - Burst write adds three qwords, ack held three more clocks.
// - Queue hit: ack two clocks after strobe, data two clocks later.
// - Block read extends ack and output enable three clocks.
// - Two-block prefetch queue; second-block hit or miss costs latency.
// - Page miss: ack with hold two clocks after latch; precharge later.
// - Precharge two clocks when bit 12 set else three; row address out.
// - Miss fetches two blocks, requested first, leaving queue half read.
// - First-block hit ends without prefetch; second-block hit refills queue.
// - First fetched block has three hold wait clocks between qwords.
// - Fast DRAM access when bits 12 and 22 both set.
// - Non-memory write acked without hold, VL address driven, data buffered.
// - Crossed write starts all enables; 16-bit slave swaps halves.
// - No bursts on crossings; block permit negated, last signal held.
// - Crossed read takes two dwords, each answered with ready return.
// - After last dword: hold off, then ack off and quadword driven together next.
// - Crossed read waits with ack and hold; all enables asserted.
`timescale 1ns/10ps
module cbb_bridge #(
	parameter int unsigned ROW_W = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic transceiver_emulation_strap,
	input wire logic [31:0] config_register_zero,
	input wire logic [63:0] cpu_addr_data_bus,
	input wire logic xcvr_latch_enable_n,
	input wire logic group_address_strobe,
	output logic group_transfer_ack,
	output logic group_transfer_hold,
	output logic group_block_permit,
	output logic xcvr_output_enable_n,
	output logic [63:0] cpu_data_out,
	output logic [ROW_W-1:0] dram_address_lines,
	output logic dram_row_strobe_n,
	output logic dram_wr_valid,
	output logic [63:0] dram_wr_data,
	input wire logic [63:0] dram_data_lines,
	output logic [31:2] vl_addr,
	output logic [3:0] vl_byte_en_n,
	output logic vl_addr_strobe_n,
	output logic vl_blast_n,
	output logic vl_write,
	output logic [31:0] vl_wdata,
	output logic vl_rdy_return_n,
	input wire logic vl_dev_sel_n,
	input wire logic vl_ready_n,
	input wire logic vl_bs16_n,
	input wire logic [31:0] vl_rdata,
	input wire logic mem_decode_hit,
	output logic vl_fast_select
);
	cbb_pkg::cbb_state_t state_r;
	logic [63:0] addr_r;
	logic [3:0] cnt_r;
	logic [1:0] beat_r;
	logic [63:0] wq_mem [cbb_pkg::WQ_DEPTH];
	logic [2:0] wq_wp_r, wq_rp_r;
	logic [3:0] wq_cnt_r;
	logic [63:0] pfq_mem [cbb_pkg::PFQ_QWORDS];
	logic [28:0] pfq_base_r;
	logic pfq_valid_r;
	logic [2:0] fill_r;
	logic [63:0] vl_buf_r;
	logic [1:0] vl_step_r;
	logic wq_full, wq_push, wq_pop, pf_hit1, pf_hit2, is_block, fast_dram;

	assign is_block = addr_r[cbb_pkg::STAT_BLOCK_BIT];
	assign fast_dram = config_register_zero[cbb_pkg::CFG_PRE_BIT] & config_register_zero[cbb_pkg::CFG_FAST_BIT];
	assign wq_full = wq_cnt_r == 4'(cbb_pkg::WQ_DEPTH);
	assign pf_hit1 = pfq_valid_r && addr_r[31:5] == pfq_base_r[28:2];
	assign pf_hit2 = pfq_valid_r && addr_r[31:5] == pfq_base_r[28:2] + 27'h1;
	assign wq_push = state_r == cbb_pkg::CBB_WR_DATA && !xcvr_latch_enable_n && !wq_full;
	assign wq_pop = wq_cnt_r != 4'h0 && (state_r != cbb_pkg::CBB_WR_DATA || wq_full);

	// Newest latched address wins until the strobe starts the cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_r <= 64'h0000_0000_0000_0000;
		end else if (state_r == cbb_pkg::CBB_IDLE && !xcvr_latch_enable_n &&
				transceiver_emulation_strap) begin
			addr_r <= cpu_addr_data_bus;
		end
	end

	// Write queue drains to DRAM whenever no write is loading, or when full.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wq_wp_r <= 3'h0;
			wq_rp_r <= 3'h0;
			wq_cnt_r <= 4'h0;
			dram_wr_valid <= 1'b0;
			dram_wr_data <= 64'h0000_0000_0000_0000;
		end else begin
			dram_wr_valid <= wq_pop;
			if (wq_pop) begin
				dram_wr_data <= wq_mem[wq_rp_r];
				wq_rp_r <= wq_rp_r + 3'h1;
			end
			if (wq_push) begin
				wq_mem[wq_wp_r] <= cpu_addr_data_bus;
				wq_wp_r <= wq_wp_r + 3'h1;
			end
			wq_cnt_r <= wq_cnt_r + 4'(wq_push) - 4'(wq_pop);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= cbb_pkg::CBB_IDLE;
			cnt_r <= 4'h0;
			beat_r <= 2'h0;
			fill_r <= 3'h0;
			vl_step_r <= 2'h0;
			pfq_valid_r <= 1'b0;
			pfq_base_r <= 29'h0000_0000;
			vl_buf_r <= 64'h0000_0000_0000_0000;
			group_transfer_ack <= 1'b0;
			group_transfer_hold <= 1'b0;
			group_block_permit <= 1'b0;
			xcvr_output_enable_n <= 1'b1;
			cpu_data_out <= 64'h0000_0000_0000_0000;
			dram_address_lines <= '0;
			dram_row_strobe_n <= 1'b1;
			vl_addr <= 30'h0000_0000;
			vl_byte_en_n <= 4'hf;
			vl_addr_strobe_n <= 1'b1;
			vl_blast_n <= 1'b1;
			vl_write <= 1'b0;
			vl_wdata <= 32'h0000_0000;
			vl_rdy_return_n <= 1'b1;
		end else begin
			vl_addr_strobe_n <= 1'b1;
			vl_rdy_return_n <= 1'b1;
			unique case (state_r)
				cbb_pkg::CBB_IDLE: begin
					group_transfer_ack <= 1'b0;
					group_transfer_hold <= 1'b0;
					xcvr_output_enable_n <= 1'b1;
					vl_blast_n <= 1'b1;
					if (group_address_strobe) begin
						state_r <= cbb_pkg::CBB_DECODE;
					end
				end
				cbb_pkg::CBB_DECODE: begin
					beat_r <= 2'h0;
					cnt_r <= 4'h0;
					group_transfer_ack <= 1'b1;
					group_block_permit <= mem_decode_hit;
					if (!mem_decode_hit) begin
						vl_addr <= addr_r[31:2];
						vl_write <= addr_r[cbb_pkg::STAT_WRITE_BIT];
						vl_byte_en_n <= 4'h0;
						vl_blast_n <= 1'b0;
						vl_addr_strobe_n <= 1'b0;
						vl_step_r <= 2'h0;
						group_transfer_hold <= !addr_r[cbb_pkg::STAT_WRITE_BIT];
						state_r <= addr_r[cbb_pkg::STAT_WRITE_BIT] ? cbb_pkg::CBB_VL_WR :
							cbb_pkg::CBB_VL_RD;
					end else if (addr_r[cbb_pkg::STAT_WRITE_BIT]) begin
						group_transfer_hold <= wq_full;
						state_r <= wq_full ? cbb_pkg::CBB_WR_DRAIN : cbb_pkg::CBB_WR_DATA;
					end else if (pf_hit1 || pf_hit2) begin
						group_transfer_hold <= 1'b0;
						group_transfer_ack <= 1'b0;
						state_r <= cbb_pkg::CBB_RD_HIT;
					end else begin
						group_transfer_hold <= 1'b1;
						dram_address_lines <= addr_r[ROW_W+13:14];
						state_r <= cbb_pkg::CBB_PRECHG;
					end
				end
				cbb_pkg::CBB_WR_DRAIN: begin
					if (!wq_full) begin
						group_transfer_hold <= 1'b0;
						state_r <= cbb_pkg::CBB_WR_DATA;
					end
				end
				cbb_pkg::CBB_WR_DATA: begin
					if (!xcvr_latch_enable_n) begin
						beat_r <= beat_r + 2'h1;
						if (!is_block || beat_r == 2'h3) begin
							group_transfer_ack <= 1'b0;
							state_r <= cbb_pkg::CBB_IDLE;
						end
					end
				end
				// Data follows the acknowledge by two clocks, so stay here two clocks.
				cbb_pkg::CBB_RD_HIT: begin
					group_transfer_ack <= 1'b1;
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= cbb_pkg::CBB_RD_OUT;
					end
				end
				cbb_pkg::CBB_RD_OUT: begin
					xcvr_output_enable_n <= 1'b0;
					cpu_data_out <= pfq_mem[{addr_r[5], addr_r[4:3] + beat_r}];
					beat_r <= beat_r + 2'h1;
					if (!is_block || beat_r == 2'h3) begin
						group_transfer_ack <= 1'b0;
						if (pf_hit2) begin
							pfq_base_r <= pfq_base_r + 29'h8;
							fill_r <= 3'h0;
							cnt_r <= 4'h0;
							dram_address_lines <= addr_r[ROW_W+13:14];
							state_r <= cbb_pkg::CBB_PRECHG;
						end else begin
							state_r <= cbb_pkg::CBB_IDLE;
						end
					end
				end
				cbb_pkg::CBB_PRECHG: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == cbb_pkg::PRE_START_CLKS - 4'h1) begin
						dram_row_strobe_n <= 1'b1;
					end
					if (cnt_r == cbb_pkg::PRE_START_CLKS - 4'h1 + (config_register_zero[cbb_pkg::CFG_PRE_BIT] ?
							cbb_pkg::PRE_FAST_CLKS : cbb_pkg::PRE_SLOW_CLKS)) begin
						dram_row_strobe_n <= 1'b0;
						cnt_r <= fast_dram ? 4'h1 : 4'h0;
						fill_r <= 3'h0;
						if (group_transfer_ack) begin
							pfq_base_r <= {addr_r[31:5], 2'h0};
						end
						state_r <= cbb_pkg::CBB_FETCH;
					end
				end
				cbb_pkg::CBB_FETCH: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r >= cbb_pkg::MEM_DELAY_CLKS - 4'h1) begin
						cnt_r <= 4'h0;
						pfq_mem[fill_r] <= dram_data_lines;
						fill_r <= fill_r + 3'h1;
						if (group_transfer_ack && fill_r[2] == 1'b0) begin
							cpu_data_out <= dram_data_lines;
							xcvr_output_enable_n <= 1'b0;
							group_transfer_hold <= 1'b0;
							if (!is_block || fill_r == 3'h3) begin
								group_transfer_ack <= 1'b0;
							end
						end else begin
							group_transfer_hold <= 1'b1;
						end
						if (fill_r == 3'h7) begin
							pfq_valid_r <= 1'b1;
							state_r <= cbb_pkg::CBB_IDLE;
						end
					end else if (group_transfer_ack) begin
						group_transfer_hold <= 1'b1;
					end
				end
				cbb_pkg::CBB_VL_WR: begin
					if (group_transfer_ack && !group_transfer_hold) begin
						vl_buf_r <= cpu_addr_data_bus;
						vl_wdata <= cpu_addr_data_bus[31:0];
						group_transfer_ack <= 1'b0;
					end else if (!vl_ready_n) begin
						vl_step_r <= vl_step_r + 2'h1;
						vl_addr_strobe_n <= 1'b0;
						if (!vl_bs16_n && !vl_step_r[0]) begin
							vl_byte_en_n <= 4'h3;
						end else if (!vl_step_r[1]) begin
							vl_addr <= vl_addr + 30'h1;
							vl_byte_en_n <= 4'h0;
							vl_wdata <= vl_buf_r[63:32];
							vl_step_r <= 2'h2;
						end else begin
							vl_addr_strobe_n <= 1'b1;
							state_r <= cbb_pkg::CBB_IDLE;
						end
					end
				end
				cbb_pkg::CBB_VL_RD: begin
					if (!vl_ready_n) begin
						vl_rdy_return_n <= 1'b0;
						vl_step_r <= vl_step_r + 2'h1;
						if (vl_step_r == 2'h0) begin
							vl_buf_r[31:0] <= vl_rdata;
							vl_addr <= vl_addr + 30'h1;
							vl_addr_strobe_n <= 1'b0;
						end else begin
							vl_buf_r[63:32] <= vl_rdata;
							group_transfer_hold <= 1'b0;
							state_r <= cbb_pkg::CBB_VL_DONE;
						end
					end
				end
				cbb_pkg::CBB_VL_DONE: begin
					group_transfer_ack <= 1'b0;
					xcvr_output_enable_n <= 1'b0;
					cpu_data_out <= vl_buf_r;
					state_r <= cbb_pkg::CBB_IDLE;
				end
				default: begin
					state_r <= cbb_pkg::CBB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vl_fast_select <= 1'b0;
		end else begin
			vl_fast_select <= config_register_zero[cbb_pkg::CFG_VLFAST_BIT] && cbb_pkg::CLK_MHZ <= 33;
		end
	end

	write_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == cbb_pkg::CBB_DECODE && mem_decode_hit && addr_r[cbb_pkg::STAT_WRITE_BIT] && !wq_full
		|=> group_transfer_ack && !group_transfer_hold)
		else $error("memory write not acked without hold");
	full_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == cbb_pkg::CBB_DECODE && mem_decode_hit && addr_r[cbb_pkg::STAT_WRITE_BIT] && wq_full
		|=> group_transfer_hold)
		else $error("full queue did not hold write");
	hit_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == cbb_pkg::CBB_RD_HIT && cnt_r == 4'h0
		|=> group_transfer_ack ##2 !xcvr_output_enable_n)
		else $error("queue hit ack timing wrong");
	cross_permit_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == cbb_pkg::CBB_DECODE && !mem_decode_hit
		|=> !group_block_permit && !vl_blast_n)
		else $error("crossing allowed a burst");
	cross_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == cbb_pkg::CBB_DECODE && !mem_decode_hit
		|=> vl_byte_en_n == 4'h0 && !vl_addr_strobe_n)
		else $error("crossing did not start with all enables");
	vl_done_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == cbb_pkg::CBB_VL_RD && !vl_ready_n && vl_step_r == 2'h1
		|=> !group_transfer_hold ##1 !group_transfer_ack)
		else $error("crossed read end sequence wrong");
	queue_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		wq_cnt_r <= 4'(cbb_pkg::WQ_DEPTH))
		else $error("write queue overflow");
	fast_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(config_register_zero[cbb_pkg::CFG_VLFAST_BIT]) |=> vl_fast_select)
		else $error("fast select not raised");
endmodule

//--- logic/cbb_pkg.sv
// Constants shared by the processor-bus bridge.
package cbb_pkg;
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned WQ_DEPTH = 8;
	localparam int unsigned PFQ_QWORDS = 8;
	localparam int unsigned BLOCK_QWORDS = 4;
	localparam logic [3:0] WR_END_CLKS = 4'h3;
	localparam logic [3:0] HIT_ACK_CLKS = 4'h2;
	localparam logic [3:0] MISS_ACK_CLKS = 4'h2;
	localparam logic [3:0] PRE_START_CLKS = 4'h2;
	localparam logic [3:0] PRE_FAST_CLKS = 4'h2;
	localparam logic [3:0] PRE_SLOW_CLKS = 4'h3;
	localparam logic [3:0] MEM_DELAY_CLKS = 4'h4;
	localparam int unsigned CFG_PRE_BIT = 12;
	localparam int unsigned CFG_FAST_BIT = 22;
	localparam int unsigned CFG_VLFAST_BIT = 25;
	localparam int unsigned STAT_BLOCK_BIT = 32;
	localparam int unsigned STAT_MEM_BIT = 33;
	localparam int unsigned STAT_WRITE_BIT = 34;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	typedef enum logic [3:0] {
		CBB_IDLE = 4'b0000,
		CBB_DECODE = 4'b0001,
		CBB_WR_DATA = 4'b0010,
		CBB_WR_DRAIN = 4'b0011,
		CBB_RD_HIT = 4'b0100,
		CBB_RD_OUT = 4'b0101,
		CBB_PRECHG = 4'b0110,
		CBB_FETCH = 4'b0111,
		CBB_VL_WR = 4'b1000,
		CBB_VL_RD = 4'b1001,
		CBB_VL_DONE = 4'b1010
	} cbb_state_t;
endpackage

//--- verif/cbb_cpu_model.sv
// Processor-side model: address latch, strobe, write data and read capture.
`timescale 1ns/10ps
module cbb_cpu_model (
	input wire logic clk,
	input wire logic group_transfer_ack,
	input wire logic group_transfer_hold,
	input wire logic xcvr_output_enable_n,
	input wire logic [63:0] cpu_data_out,
	output logic [63:0] cpu_addr_data_bus,
	output logic xcvr_latch_enable_n,
	output logic group_address_strobe
);
	initial begin
		cpu_addr_data_bus = 64'h0000_0000_0000_0000;
		xcvr_latch_enable_n = 1'b1;
		group_address_strobe = 1'b0;
	end
	// Released bus lines show the inverse of the last value.
	task automatic adr(input logic [63:0] a);
		@(posedge clk);
		cpu_addr_data_bus <= a;
		xcvr_latch_enable_n <= 1'b0;
		@(posedge clk);
		xcvr_latch_enable_n <= 1'b1;
		cpu_addr_data_bus <= ~a;
	endtask
	task automatic go();
		group_address_strobe <= 1'b1;
		@(posedge clk);
		group_address_strobe <= 1'b0;
	endtask
	task automatic wr(input logic [63:0] d, output int n);
		go();
		@(posedge clk);
		cpu_addr_data_bus <= d;
		xcvr_latch_enable_n <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(group_transfer_ack === 1'b1 && group_transfer_hold === 1'b0) && n < 500);
		xcvr_latch_enable_n <= 1'b1;
		cpu_addr_data_bus <= ~d;
	endtask
	task automatic rd(output logic [63:0] q, output int dq, output logic hs);
		int n;
		int ka;
		go();
		n = 0;
		ka = -1;
		dq = -1;
		hs = 1'b0;
		while (dq < 0 && n < 500) begin
			@(posedge clk);
			n++;
			if (group_transfer_hold === 1'b1) hs = 1'b1;
			if (ka < 0 && group_transfer_ack === 1'b1 && group_transfer_hold === 1'b0) ka = n;
			if (xcvr_output_enable_n === 1'b0) begin
				q = cpu_data_out;
				dq = n - ka;
			end
		end
	endtask
endmodule

//--- verif/test_cbb_bridge.sv
// Self-checking bench for the processor-bus bridge.
`timescale 1ns/10ps
module test_cbb_bridge;
	logic clk, rst_n, hit, vl_ready_n, vl_dev_sel_n, vl_bs16_n, pend, s16, hs;
	logic xle_n, gas, ack, hold, oe_n, ras_n, wv, as_n, blast_n, fsel, gbp, vw, rr_n;
	logic [31:0] cfg, vl_rdata, rv, vwd;
	logic [63:0] dram, bus, cdo, wd, q;
	logic [10:0] ma, ma_pre;
	logic [29:0] vla;
	logic [3:0] be_n;
	logic [63:0] wq_exp[$], wq_got[$];
	logic [3:0] be_q[$];
	logic [29:0] ad_q[$];
	logic [31:0] rd_q[$], wd_q[$];
	int n_mismatch, tests_run, ras_run, ras_last, bl_err, h, dq, rr_cnt;
	cbb_bridge uut (.clk(clk), .rst_n(rst_n), .transceiver_emulation_strap(1'b1),
		.config_register_zero(cfg), .cpu_addr_data_bus(bus), .xcvr_latch_enable_n(xle_n),
		.group_address_strobe(gas), .group_transfer_ack(ack), .group_transfer_hold(hold),
		.group_block_permit(gbp), .xcvr_output_enable_n(oe_n), .cpu_data_out(cdo),
		.dram_address_lines(ma), .dram_row_strobe_n(ras_n), .dram_wr_valid(wv),
		.dram_wr_data(wd), .dram_data_lines(dram), .vl_addr(vla), .vl_byte_en_n(be_n),
		.vl_addr_strobe_n(as_n), .vl_blast_n(blast_n), .vl_write(vw), .vl_wdata(vwd),
		.vl_rdy_return_n(rr_n), .vl_dev_sel_n(vl_dev_sel_n), .vl_ready_n(vl_ready_n),
		.vl_bs16_n(vl_bs16_n), .vl_rdata(vl_rdata), .mem_decode_hit(hit),
		.vl_fast_select(fsel));
	cbb_cpu_model m (.clk(clk), .group_transfer_ack(ack), .group_transfer_hold(hold),
		.xcvr_output_enable_n(oe_n), .cpu_data_out(cdo), .cpu_addr_data_bus(bus),
		.xcvr_latch_enable_n(xle_n), .group_address_strobe(gas));
	// VL slave with one wait state, plus monitors of DRAM and VL traffic.
	always @(posedge clk) begin
		pend <= (as_n === 1'b0);
		vl_dev_sel_n <= !(as_n === 1'b0);
		vl_ready_n <= !pend;
		vl_bs16_n <= !(pend && s16);
		if (as_n === 1'b0) begin
			be_q.push_back(be_n);
			ad_q.push_back(vla);
			wd_q.push_back(vwd);
			if (blast_n !== 1'b0) bl_err++;
		end
		if (pend) begin
			rv = $urandom;
			rd_q.push_back(rv);
			vl_rdata <= rv;
		end else vl_rdata <= ~vl_rdata;
		if (wv === 1'b1) wq_got.push_back(wd);
		if (rr_n === 1'b0) rr_cnt++;
		if (ras_n === 1'b1) begin
			ras_run++;
			ma_pre <= ma;
		end else begin
			if (ras_run > 0) ras_last = ras_run;
			ras_run = 0;
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp);
		chk(64'(got), 64'(exp));
	endtask
	task automatic done(input string s);
		$display("test %0s done", s);
	endtask
	task automatic results();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [63:0] st(input logic [31:0] a, input logic w);
		logic [63:0] s;
		s = {32'h0000_0000, a};
		s[cbb_pkg::STAT_MEM_BIT] = 1'b1;
		s[cbb_pkg::STAT_WRITE_BIT] = w;
		return s;
	endfunction
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2_000_000;
		n_mismatch++;
		results();
	end
	initial begin
		logic [31:0] a;
		logic [63:0] d, p;
		rst_n = 1'b0;
		hit = 1'b1;
		s16 = 1'b0;
		cfg = 32'h0000_0000;
		dram = 64'h0000_0000_0000_0000;
		vl_rdata = 32'h0000_0000;
		{vl_ready_n, vl_dev_sel_n, vl_bs16_n, pend} = 4'hE;
		void'($urandom(32'hf64e));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk({ack, hold, oe_n, as_n, be_n}, 8'h3F);
		done("reset");
		for (int i = 0; i < 12; i++) begin
			a = $urandom & 32'h00ff_fff8;
			d = {$urandom, $urandom};
			wq_exp.push_back(d);
			m.adr(st(a, 1'b1));
			m.wr(d, h);
			if (i < 8) chkn(h, 1);
		end
		repeat (200) @(posedge clk);
		chkn(wq_got.size(), 12);
		foreach (wq_exp[i]) chk(wq_got[i], wq_exp[i]);
		done("write queue");
		for (int i = 0; i < 3; i++) begin
			cfg <= i[0] ? 32'h0040_1000 : 32'h0000_0000;
			a = 32'(i + 1) << 15;
			p = {$urandom, $urandom};
			dram <= p;
			m.adr(st(a, 1'b0));
			m.rd(q, dq, hs);
			chk(q, p);
			chk(hs, 1'b1);
			if (i > 0) chkn(ras_last, i[0] ? 2 : 3);
			if (i > 0) chk(ma_pre, a[24:14]);
			repeat (40) @(posedge clk);
		end
		dram <= ~p;
		m.adr(st(a + 32'h0000_0008, 1'b0));
		m.rd(q, dq, hs);
		chk(q, p);
		chk(hs, 1'b0);
		chkn(dq, 2);
		chk(gbp, 1'b1);
		done("memory read");
		hit <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			s16 = i[0];
			be_q.delete();
			ad_q.delete();
			wd_q.delete();
			a = $urandom & 32'hffff_fff8;
			d = {$urandom, $urandom};
			m.adr(st(32'h0000_0000, 1'b1));
			m.adr(st(a, 1'b1));
			m.wr(d, h);
			chkn(h, 1);
			chk(vw, 1'b1);
			chk(gbp, 1'b0);
			repeat (60) @(posedge clk);
			chkn(be_q.size(), i[0] ? 4 : 2);
			chk(be_q[0], 4'h0);
			chk(ad_q[0], a[31:2]);
			chk(ad_q[be_q.size() - 1], a[31:2] + 30'h1);
			chk(wd_q[be_q.size() - 1], d[63:32]);
			if (i > 0) chk(be_q[1] !== 4'h0, 1'b1);
		end
		s16 = 1'b0;
		be_q.delete();
		rd_q.delete();
		rr_cnt = 0;
		m.adr(st(a, 1'b0));
		m.rd(q, dq, hs);
		chk(q, {rd_q[1], rd_q[0]});
		chk(hs, 1'b1);
		chkn(rr_cnt, 2);
		chk(vw, 1'b0);
		chk(be_q[0] | be_q[1], 4'h0);
		chkn(bl_err, 0);
		done("vl crossing");
		for (int i = 0; i < 2; i++) begin
			cfg <= i[0] ? 32'h0200_0000 : 32'h0000_1000;
			repeat (3) @(posedge clk);
			chk(fsel, i[0]);
		end
		done("fast select");
		results();
	end
endmodule
